// ===== cmf_climate_seq.sv
// What this block does
// R1: Power off: outputs idle, buttons ignored
// R2: Mode button steps to next available mode
// R3: Fan button steps low, medium, high, auto
// R4: Heat pump config: cool/fan skip medium
// R5: Fan-only energizes fan after five seconds
// R6: Mode and fan stay displayed until changed
// R7: Up/down change set-point, shown on display
// R8: Cooling waits two minutes before compressor
// R9: Compressor off at set-point, two-minute restart
// R10: Fixed fan runs on, auto follows compressor
// R11: Heat pump mode uses same compressor delays
// R12: Furnace mode keeps fan off
// R13: Furnace mode inhibits compressor
// R14: Heat strip never offers high speed
// R15: Heat strip with heat pump: low, auto
// R16: Strip cycles on set-point, auto fan follows
// R17: Zone button steps zones, per-zone settings
// R18: Selected zone flashes thirty seconds
// R19: Delays counted in clocks, cleared on change
`timescale 1ns/1ps
`default_nettype none
module cmf_climate_seq #(
  parameter int NZ = 4,
  parameter logic [31:0] FAN_CYC = 32'(cmf_pkg::FAN_CYC),
  parameter logic [31:0] COMP_CYC = 32'(cmf_pkg::COMP_CYC),
  parameter logic [31:0] FLASH_CYC = 32'(cmf_pkg::FLASH_CYC)
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic power_sw,
  input wire logic btn_mode,
  input wire logic btn_fan,
  input wire logic btn_up,
  input wire logic btn_down,
  input wire logic btn_zone,
  input wire logic [NZ*7-1:0] room_temp,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic [5:0] disp_mode,
  output logic [3:0] disp_fan,
  output logic [6:0] disp_setp,
  output logic [1:0] disp_zone,
  output logic zone_flash,
  output logic [NZ-1:0] comp_o,
  output logic [NZ-1:0] fan_lo_o,
  output logic [NZ-1:0] fan_med_o,
  output logic [NZ-1:0] fan_hi_o,
  output logic [NZ-1:0] strip_o,
  output logic [NZ-1:0] furn_o
);
  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic logic mode_ok(cmf_pkg::cmf_mode_t m, logic [5:0] c);
    case (m)
      cmf_pkg::M_HP: mode_ok = c[cmf_pkg::CFG_HP_BIT];
      cmf_pkg::M_FURN: mode_ok = c[cmf_pkg::CFG_FURN_BIT];
      cmf_pkg::M_STRIP: mode_ok = c[cmf_pkg::CFG_STRIP_BIT];
      default: mode_ok = 1'b1;
    endcase
  endfunction : mode_ok

  function automatic logic fan_ok(cmf_pkg::cmf_mode_t m, cmf_pkg::cmf_fan_t f, logic hp);
    if (m == cmf_pkg::M_STRIP) begin
      fan_ok = (f != cmf_pkg::F_HIGH) && !(hp && f == cmf_pkg::F_MED); // [R14] [R15]
    end else if (hp && (m == cmf_pkg::M_FAN || m == cmf_pkg::M_COOL)) begin
      fan_ok = (f != cmf_pkg::F_MED); // [R4]
    end else begin
      fan_ok = 1'b1;
    end
  endfunction : fan_ok

  function automatic cmf_pkg::cmf_mode_t next_mode(cmf_pkg::cmf_mode_t m, logic [5:0] c);
    cmf_pkg::cmf_mode_t r;
    r = m;
    for (int i = 0; i < 6; i++) begin
      r = (r == cmf_pkg::M_STRIP) ? cmf_pkg::M_OFF : cmf_pkg::cmf_mode_t'(r + 3'h1);
      if (mode_ok(r, c)) break;
    end
    next_mode = r;
  endfunction : next_mode

  function automatic cmf_pkg::cmf_fan_t next_fan(cmf_pkg::cmf_mode_t m, cmf_pkg::cmf_fan_t f,
                                                 logic hp);
    cmf_pkg::cmf_fan_t r;
    r = f;
    for (int i = 0; i < 4; i++) begin
      r = cmf_pkg::cmf_fan_t'(r + 2'h1);
      if (fan_ok(m, r, hp)) break;
    end
    next_fan = r;
  endfunction : next_fan

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [cmf_pkg::NPIN-1:0] pins, s1_ff, s2_ff, s3_ff, st_ff, nxt_st, rel;
  logic pwr;
  assign pins = {btn_zone, btn_down, btn_up, btn_fan, btn_mode, power_sw};

  always_comb begin
    // A level counts only once two later stages agree
    nxt_st = st_ff;
    for (int i = 0; i < cmf_pkg::NPIN; i++) begin
      if (s2_ff[i] == s3_ff[i]) nxt_st[i] = s3_ff[i];
    end
    rel = st_ff & ~nxt_st & {{(cmf_pkg::NPIN-1){st_ff[cmf_pkg::P_PWR]}}, 1'b0}; // [R1]
    rel[cmf_pkg::P_PWR] = 1'b0;
  end
  assign pwr = st_ff[cmf_pkg::P_PWR];

  always_ff @(posedge clock) begin
    if (rst) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      st_ff <= '0;
    end else if (ce) begin
      s1_ff <= pins;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  logic [5:0] cfg_ff, nxt_cfg;
  logic [31:0] rdata_ff, nxt_rdata;
  logic cfg_hp;
  logic [1:0] cfg_last;
  assign cfg_hp = cfg_ff[cmf_pkg::CFG_HP_BIT];
  assign cfg_last = cfg_ff[cmf_pkg::CFG_NZ_LSB +: 2];

  // ----------------------------------------
  // Panel state, per zone
  // ----------------------------------------
  cmf_pkg::cmf_mode_t mode_ff [NZ], nxt_mode [NZ];
  cmf_pkg::cmf_fan_t fan_ff [NZ], nxt_fan [NZ];
  logic [6:0] setp_ff [NZ], nxt_setp [NZ];
  logic [NZ-1:0] chg_ff, nxt_chg;
  logic [1:0] zone_ff, nxt_zone;
  logic [31:0] flash_ff, nxt_flash;
  logic [5:0] dmode_ff, nxt_dmode;
  logic [3:0] dfan_ff, nxt_dfan;
  logic [6:0] dsetp_ff, nxt_dsetp;
  logic flash_on_ff, nxt_flash_on;

  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_rdata = '0;
    if (wr && addr == cmf_pkg::ADDR_CFG) nxt_cfg = wdata[5:0];
    if (rd) begin
      case (addr)
        cmf_pkg::ADDR_CFG: nxt_rdata = {26'h0, cfg_ff};
        cmf_pkg::ADDR_STAT: nxt_rdata = {14'h0, setp_ff[zone_ff], 1'b0, fan_ff[zone_ff],
                                         1'b0, mode_ff[zone_ff], flash_on_ff, zone_ff, pwr};
        cmf_pkg::ADDR_OUT: nxt_rdata = {26'h0, furn_o[0], strip_o[0], fan_hi_o[0],
                                        fan_med_o[0], fan_lo_o[0], comp_o[0]};
        default: nxt_rdata = '0;
      endcase
    end
    nxt_mode = mode_ff;
    nxt_fan = fan_ff;
    nxt_setp = setp_ff;
    nxt_chg = '0;
    nxt_zone = zone_ff;
    nxt_flash = (flash_ff != 32'h0) ? flash_ff - 32'h1 : flash_ff; // [R18]
    if (rel[cmf_pkg::P_ZONE]) begin
      nxt_zone = (zone_ff >= cfg_last) ? 2'h0 : zone_ff + 2'h1; // [R17]
      nxt_flash = FLASH_CYC; // [R18]
    end
    if (rel[cmf_pkg::P_MODE]) begin
      nxt_mode[zone_ff] = next_mode(mode_ff[zone_ff], cfg_ff); // [R2]
      if (!fan_ok(nxt_mode[zone_ff], fan_ff[zone_ff], cfg_hp)) nxt_fan[zone_ff] = cmf_pkg::F_LOW;
      nxt_chg[zone_ff] = 1'b1; // [R19]
    end
    if (rel[cmf_pkg::P_FAN]) begin
      nxt_fan[zone_ff] = next_fan(mode_ff[zone_ff], fan_ff[zone_ff], cfg_hp); // [R3]
      nxt_chg[zone_ff] = (mode_ff[zone_ff] == cmf_pkg::M_FAN); // [R5]
    end
    if (rel[cmf_pkg::P_UP] && setp_ff[zone_ff] < cmf_pkg::SETP_MAX) begin
      nxt_setp[zone_ff] = setp_ff[zone_ff] + 7'h1; // [R7]
    end
    if (rel[cmf_pkg::P_DOWN] && setp_ff[zone_ff] > cmf_pkg::SETP_MIN) begin
      nxt_setp[zone_ff] = setp_ff[zone_ff] - 7'h1; // [R7]
    end
    // Display mirrors the selected zone until a press changes it
    nxt_dmode = 6'h01 << nxt_mode[nxt_zone]; // [R6]
    nxt_dfan = 4'h1 << nxt_fan[nxt_zone]; // [R6]
    nxt_dsetp = nxt_setp[nxt_zone]; // [R7]
    nxt_flash_on = (nxt_flash != 32'h0); // [R18]
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cfg_ff <= cmf_pkg::CFG_RST;
      rdata_ff <= '0;
      for (int z = 0; z < NZ; z++) begin
        mode_ff[z] <= cmf_pkg::M_OFF;
        fan_ff[z] <= cmf_pkg::F_LOW;
        setp_ff[z] <= cmf_pkg::SETP_RST;
      end
      chg_ff <= '0;
      zone_ff <= 2'h0;
      flash_ff <= '0;
      flash_on_ff <= 1'b0;
      dmode_ff <= 6'h01;
      dfan_ff <= 4'h1;
      dsetp_ff <= cmf_pkg::SETP_RST;
    end else if (ce) begin
      cfg_ff <= nxt_cfg;
      rdata_ff <= nxt_rdata;
      mode_ff <= nxt_mode;
      fan_ff <= nxt_fan;
      setp_ff <= nxt_setp;
      chg_ff <= nxt_chg;
      zone_ff <= nxt_zone;
      flash_ff <= nxt_flash;
      flash_on_ff <= nxt_flash_on;
      dmode_ff <= nxt_dmode;
      dfan_ff <= nxt_dfan;
      dsetp_ff <= nxt_dsetp;
    end
  end

  assign rdata = rdata_ff;
  assign disp_mode = dmode_ff;
  assign disp_fan = dfan_ff;
  assign disp_setp = dsetp_ff;
  assign disp_zone = zone_ff;
  assign zone_flash = flash_on_ff;

  // ----------------------------------------
  // Appliance sequencing, per zone
  // ----------------------------------------
  for (genvar z = 0; z < NZ; z++) begin : zg
    logic [31:0] cnt_ff, nxt_cnt;
    logic comp_ff, nxt_comp;
    logic [4:0] out_ff, nxt_out;
    logic [6:0] temp;
    logic dem, cnt_run, run;
    cmf_pkg::cmf_mode_t md;
    assign temp = room_temp[z*7 +: 7];

    always_comb begin
      md = pwr ? mode_ff[z] : cmf_pkg::M_OFF; // [R1]
      dem = (md == cmf_pkg::M_COOL) ? (temp > setp_ff[z]) : (temp < setp_ff[z]);
      case (md)
        cmf_pkg::M_FAN: cnt_run = 1'b1; // [R5]
        cmf_pkg::M_COOL, cmf_pkg::M_HP: cnt_run = dem && !comp_ff; // [R8] [R9] [R11]
        default: cnt_run = 1'b0;
      endcase
      // Second and minute delays are counted in plain clocks, no prescaler
      nxt_cnt = cnt_ff;
      if (chg_ff[z] || !cnt_run) begin
        nxt_cnt = '0; // [R19]
      end else if (cnt_ff != ((md == cmf_pkg::M_FAN) ? FAN_CYC : COMP_CYC)) begin
        nxt_cnt = cnt_ff + 32'h1;
      end
      nxt_comp = 1'b0;
      if ((md == cmf_pkg::M_COOL || md == cmf_pkg::M_HP) && !chg_ff[z] && dem) begin
        nxt_comp = comp_ff || (cnt_ff == COMP_CYC); // [R8] [R9] [R11] [R13]
      end
      case (md)
        cmf_pkg::M_FAN: run = (cnt_ff == FAN_CYC); // [R5]
        cmf_pkg::M_COOL, cmf_pkg::M_HP: run = (fan_ff[z] != cmf_pkg::F_AUTO) || nxt_comp; // [R10]
        cmf_pkg::M_STRIP: run = (fan_ff[z] != cmf_pkg::F_AUTO) || dem; // [R16]
        default: run = 1'b0; // [R12]
      endcase
      // Automatic speed runs low; load-based speed is not handled here
      nxt_out = {md == cmf_pkg::M_FURN && dem, md == cmf_pkg::M_STRIP && dem,
                 run && fan_ff[z] == cmf_pkg::F_HIGH, run && fan_ff[z] == cmf_pkg::F_MED,
                 run && (fan_ff[z] == cmf_pkg::F_LOW || fan_ff[z] == cmf_pkg::F_AUTO)}; // [R16]
    end

    always_ff @(posedge clock) begin
      if (rst) begin
        cnt_ff <= '0;
        comp_ff <= 1'b0;
        out_ff <= '0;
      end else if (ce) begin
        cnt_ff <= nxt_cnt;
        comp_ff <= nxt_comp;
        out_ff <= nxt_out;
      end
    end

    assign comp_o[z] = comp_ff;
    assign {furn_o[z], strip_o[z], fan_hi_o[z], fan_med_o[z], fan_lo_o[z]} = out_ff;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_pwr_off_idle: assert property (ce && !pwr |=> !comp_o[0] && !strip_o[0] && !furn_o[0]) // [R1]
    else $error("output active while power off");
  a_mode_step: assert property (ce && rel[cmf_pkg::P_MODE] |=> // [R2]
    mode_ff[$past(zone_ff)] != $past(mode_ff[zone_ff]))
    else $error("mode press did not advance mode");
  a_fan_step: assert property (ce && rel[cmf_pkg::P_FAN] |=> // [R3]
    fan_ff[$past(zone_ff)] != $past(fan_ff[zone_ff]) &&
    dfan_ff == (4'h1 << fan_ff[zone_ff]))
    else $error("fan press did not advance fan");
  a_hp_no_med: assert property (cfg_hp && (mode_ff[0] == cmf_pkg::M_COOL || // [R4]
    mode_ff[0] == cmf_pkg::M_FAN) && !rel[cmf_pkg::P_MODE] |-> fan_ff[0] != cmf_pkg::F_MED)
    else $error("medium offered with heat pump");
  a_strip_no_hi: assert property (mode_ff[0] == cmf_pkg::M_STRIP |-> // [R14]
    fan_ff[0] != cmf_pkg::F_HIGH)
    else $error("high speed in heat strip");
  a_furn_quiet: assert property (ce && mode_ff[0] == cmf_pkg::M_FURN |=> // [R12] [R13]
    !comp_o[0] && !fan_lo_o[0] && !fan_med_o[0] && !fan_hi_o[0])
    else $error("fan or compressor in furnace");
  a_comp_delay: assert property ($rose(comp_o[0]) |-> $past(zg[0].cnt_ff) == COMP_CYC) // [R8]
    else $error("compressor started early");
  a_setp_up: assert property (ce && rel[cmf_pkg::P_UP] && !rel[cmf_pkg::P_DOWN] && // [R7]
    setp_ff[zone_ff] < cmf_pkg::SETP_MAX |=>
    setp_ff[$past(zone_ff)] == $past(setp_ff[zone_ff]) + 7'h1)
    else $error("set-point did not rise");
  a_zone_flash: assert property (ce && rel[cmf_pkg::P_ZONE] |=> zone_flash) // [R18]
    else $error("zone not flashing");

  c_comp_on: cover property ($rose(comp_o[0]));
  c_fan_only: cover property (mode_ff[0] == cmf_pkg::M_FAN && fan_lo_o[0]);
  c_strip_on: cover property ($rose(strip_o[0]));
  c_zone_step: cover property (ce && rel[cmf_pkg::P_ZONE] ##1 zone_ff == 2'h1);
endmodule : cmf_climate_seq
`default_nettype wire

// ===== cmf_climate_seq_test.sv
`timescale 1ns/1ps
`default_nettype none
module cmf_climate_seq_test;
  // ----------------------------------------
  // Bench signals
  // ----------------------------------------
  localparam int NZ = 4;
  localparam int FC = 20;
  localparam int CC = 50;
  localparam int LC = 30;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  // Panel pins, indexed by the package pin numbers
  logic [5:0] pin = 6'h00;
  logic [NZ*7-1:0] temp_cmd = {NZ{7'h48}};
  logic [NZ*7-1:0] room_temp;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [31:0] d;
  logic [5:0] disp_mode;
  logic [3:0] disp_fan;
  logic [6:0] disp_setp;
  logic [1:0] disp_zone;
  logic zone_flash;
  logic [NZ-1:0] comp_o, fan_lo_o, fan_med_o, fan_hi_o, strip_o, furn_o;
  int mismatches = 0;
  int checks_done = 0;
  int n;
  always #20 clock = ~clock;
  cmf_room_model #(.NZ(NZ)) u_cmf_room_model (.clock(clock), .rst(rst),
    .temp_cmd(temp_cmd), .room_temp(room_temp));
  cmf_climate_seq #(.NZ(NZ), .FAN_CYC(32'(FC)), .COMP_CYC(32'(CC)), .FLASH_CYC(32'(LC)))
    u_cmf_climate_seq (.clock(clock), .rst(rst), .ce(ce), .power_sw(pin[0]),
    .btn_mode(pin[1]), .btn_fan(pin[2]), .btn_up(pin[3]), .btn_down(pin[4]),
    .btn_zone(pin[5]), .room_temp(room_temp), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .disp_mode(disp_mode), .disp_fan(disp_fan),
    .disp_setp(disp_setp), .disp_zone(disp_zone), .zone_flash(zone_flash),
    .comp_o(comp_o), .fan_lo_o(fan_lo_o), .fan_med_o(fan_med_o), .fan_hi_o(fan_hi_o),
    .strip_o(strip_o), .furn_o(furn_o));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
  endtask : tick
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results
  // Stable level needs four edges, so hold well past it
  task automatic press(input int p);
    pin[p] <= 1'b1;
    tick(6);
    pin[p] <= 1'b0;
    tick(7);
  endtask : press
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    tick(1);
    wr <= 1'b0;
  endtask : bus_wr
  task automatic bus_rd(input logic [7:0] a);
    addr <= a;
    rd <= 1'b1;
    tick(1);
    rd <= 1'b0;
    // Sample mid-cycle, where the registered read data has settled
    @(negedge clock);
    d = rdata;
    @(negedge clock);
    chk("rdata idle", 32'h00000000, rdata);
    tick(1);
  endtask : bus_rd
  task automatic wait_lvl(input int sel, input logic lvl, input int lim);
    logic [2:0] lv;
    n = 0;
    lv = {zone_flash, fan_lo_o[0], comp_o[0]};
    while (lv[sel] !== lvl && n < lim) begin
      tick(1);
      n++;
      lv = {zone_flash, fan_lo_o[0], comp_o[0]};
    end
    if (n >= lim) begin
      chk("wait bound", 32'h0, 32'h1);
      results();
    end
  endtask : wait_lvl
  task automatic goto_mode(input int m);
    for (int i = 0; i < 8 && disp_mode !== 6'(1 << m); i++) press(1);
  endtask : goto_mode
  task automatic fan_seq(input int cnt, input logic [15:0] seq);
    for (int i = 0; i < cnt; i++) begin
      press(2);
      chk("disp_fan", 32'(seq[i*4+:4]), 32'(disp_fan));
    end
  endtask : fan_seq
  task automatic comp_delay;
    wait_lvl(0, 1'b1, CC + 20);
    chk("comp delay", 32'h1, 32'(n >= CC - 2 && n <= CC + 8));
  endtask : comp_delay
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic s_power_off;
    chk("reset fan", 32'h1, 32'(disp_fan));
    chk("reset setp", 32'h48, 32'(disp_setp));
    press(1);
    chk("mode unpowered", 32'h01, 32'(disp_mode));
    bus_rd(cmf_pkg::ADDR_STAT);
    chk("stat power", 32'h0, 32'(d[0]));
  endtask : s_power_off
  task automatic s_bus_modes;
    pin[0] <= 1'b1;
    tick(8);
    bus_wr(cmf_pkg::ADDR_CFG, 32'h00000037);
    bus_rd(cmf_pkg::ADDR_CFG);
    chk("cfg", 32'h37, d);
    bus_rd(8'h0C);
    chk("unmapped", 32'h0, d);
    for (int i = 0; i < 6; i++) begin
      press(1);
      chk("disp_mode", 32'(1 << ((i + 1) % 6)), 32'(disp_mode));
    end
    bus_wr(cmf_pkg::ADDR_CFG, 32'h00000030);
    for (int i = 0; i < 3; i++) begin
      press(1);
      chk("disp_mode", 32'(1 << ((i + 1) % 3)), 32'(disp_mode));
    end
  endtask : s_bus_modes
  task automatic s_fans;
    goto_mode(1);
    fan_seq(4, 16'h1842);
    bus_wr(cmf_pkg::ADDR_CFG, 32'h00000037);
    goto_mode(2);
    fan_seq(3, 16'h0184);
    bus_wr(cmf_pkg::ADDR_CFG, 32'h00000032);
    goto_mode(5);
    fan_seq(3, 16'h0182);
    bus_wr(cmf_pkg::ADDR_CFG, 32'h00000033);
    fan_seq(2, 16'h0018);
    bus_wr(cmf_pkg::ADDR_CFG, 32'h00000030);
    goto_mode(0);
    press(1);
    wait_lvl(1, 1'b1, FC + 20);
    chk("fan delay", 32'h1, 32'(n >= FC - 4 && n <= FC + 3));
    chk("mode held", 32'h02, 32'(disp_mode));
  endtask : s_fans
  task automatic s_cool_heat;
    press(1);
    temp_cmd[6:0] <= 7'h50;
    comp_delay();
    chk("fan fixed", 32'h1, 32'(fan_lo_o[0]));
    bus_rd(cmf_pkg::ADDR_OUT);
    chk("out reg", 32'h00000003, d);
    temp_cmd[6:0] <= 7'h48;
    wait_lvl(0, 1'b0, 6);
    tick(3);
    chk("fan runs on", 32'h1, 32'(fan_lo_o[0]));
    temp_cmd[6:0] <= 7'h50;
    comp_delay();
    press(2);
    chk("fan med", 32'h1, 32'(fan_med_o[0]));
    press(2);
    chk("fan high", 32'h1, 32'(fan_hi_o[0]));
    press(2);
    temp_cmd[6:0] <= 7'h48;
    tick(4);
    chk("auto fan off", 32'h0, 32'(fan_lo_o[0]));
    bus_wr(cmf_pkg::ADDR_CFG, 32'h00000037);
    press(1);
    chk("hp mode", 32'h08, 32'(disp_mode));
    temp_cmd[6:0] <= 7'h40;
    comp_delay();
    chk("auto fan on", 32'h1, 32'(fan_lo_o[0]));
    press(1);
    tick(CC + 10);
    chk("furn call", 32'h1, 32'(furn_o[0]));
    chk("furn comp", 32'h0, 32'(comp_o[0]));
    chk("furn fan", 32'h0, 32'(fan_lo_o | fan_med_o | fan_hi_o));
    temp_cmd[6:0] <= 7'h50;
    tick(CC + 10);
    chk("furn no cool", 32'h0, 32'(comp_o[0]));
    press(1);
    temp_cmd[6:0] <= 7'h40;
    tick(5);
    chk("strip on", 32'h1, 32'(strip_o[0]));
    chk("strip fan", 32'h1, 32'(fan_lo_o[0]));
    temp_cmd[6:0] <= 7'h50;
    tick(5);
    chk("strip off", 32'h0, 32'({strip_o[0], fan_lo_o[0]}));
  endtask : s_cool_heat
  task automatic s_setp_zone;
    press(3);
    chk("setp up", 32'h49, 32'(disp_setp));
    press(4);
    press(4);
    chk("setp down", 32'h47, 32'(disp_setp));
    // With the enable low even the synchronisers hold, so the press is lost
    ce <= 1'b0;
    press(3);
    ce <= 1'b1;
    chk("ce freeze", 32'h47, 32'(disp_setp));
    press(5);
    chk("zone", 32'h1, 32'(disp_zone));
    chk("zone own mode", 32'h01, 32'(disp_mode));
    chk("flash", 32'h1, 32'(zone_flash));
    wait_lvl(2, 1'b0, LC + 20);
    chk("flash time", 32'h1, 32'(n >= LC - 6 && n <= LC + 3));
    for (int i = 0; i < 3; i++) press(5);
    chk("zone wrap", 32'h0, 32'(disp_zone));
    chk("zone0 mode", 32'h20, 32'(disp_mode));
    bus_rd(cmf_pkg::ADDR_STAT);
    chk("stat word", 32'h00023B59, d);
    temp_cmd[6:0] <= 7'h40;
    pin[0] <= 1'b0;
    tick(8);
    chk("relays off", 32'h0, 32'({comp_o, fan_lo_o, strip_o, furn_o}));
  endtask : s_setp_zone
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    tick(10);
    rst <= 1'b0;
    tick(2);
    s_power_off();
    s_bus_modes();
    s_fans();
    s_cool_heat();
    s_setp_zone();
    results();
  end
endmodule : cmf_climate_seq_test
`default_nettype wire

// ===== cmf_pkg.sv
`default_nettype none
package cmf_pkg;
  // ----------------------------------------
  // Modes and fan speeds
  // ----------------------------------------
  typedef enum logic [2:0] {M_OFF, M_FAN, M_COOL, M_HP, M_FURN, M_STRIP} cmf_mode_t;
  typedef enum logic [1:0] {F_LOW, F_MED, F_HIGH, F_AUTO} cmf_fan_t;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam longint unsigned CLK_HZ = 25_000_000;
  localparam longint unsigned FAN_DELAY_S = 5;
  localparam longint unsigned COMP_DELAY_S = 120;
  localparam longint unsigned FLASH_S = 30;
  localparam longint unsigned FAN_CYC = FAN_DELAY_S * CLK_HZ;
  localparam longint unsigned COMP_CYC = COMP_DELAY_S * CLK_HZ;
  localparam longint unsigned FLASH_CYC = FLASH_S * CLK_HZ;

  // ----------------------------------------
  // Set-point
  // ----------------------------------------
  localparam logic [6:0] SETP_MIN = 7'h28;
  localparam logic [6:0] SETP_MAX = 7'h63;
  localparam logic [6:0] SETP_RST = 7'h48;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_OUT = 8'h08;
  localparam int CFG_HP_BIT = 0;
  localparam int CFG_STRIP_BIT = 1;
  localparam int CFG_FURN_BIT = 2;
  localparam int CFG_NZ_LSB = 4;
  localparam logic [5:0] CFG_RST = 6'h00;

  // ----------------------------------------
  // Pin inputs
  // ----------------------------------------
  localparam int P_PWR = 0;
  localparam int P_MODE = 1;
  localparam int P_FAN = 2;
  localparam int P_UP = 3;
  localparam int P_DOWN = 4;
  localparam int P_ZONE = 5;
  localparam int NPIN = 6;
endpackage : cmf_pkg
`default_nettype wire

// ===== cmf_room_model.sv
`timescale 1ns/1ps
`default_nettype none
module cmf_room_model #(
  parameter int NZ = 4
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [NZ*7-1:0] temp_cmd,
  output logic [NZ*7-1:0] room_temp
);
  // ----------------------------------------
  // Room sensors
  // ----------------------------------------
  // Probes lag the room by a clock, so the block never sees a change at once
  always_ff @(posedge clock) begin
    if (rst) begin
      room_temp <= {NZ{7'h48}};
    end else begin
      room_temp <= temp_cmd;
    end
  end
endmodule : cmf_room_model
`default_nettype wire
